/* dv/spr_pin_monitor.sv */
// Behavioural model of the board logic that watches the routed pins.
`timescale 1ns/100ps
module spr_pin_monitor
	import spr_pkg::*;
(
	// Clock and reset.
	input  wire logic                       core_clk,
	input  wire logic                       rst_n,
	// Pins as seen from outside the device.
	input  wire logic [PIN_COUNT-1:0]       pin_out,
	input  wire logic [PIN_COUNT-1:0]       pin_oe,
	output logic      [INPUT_PIN_COUNT-1:0] pin_in
);
	logic [4:0]                 tick;      // Paces the pattern fed to the input-capable pins.
	logic [INPUT_PIN_COUNT-1:0] drive_pat; // Level the board puts on a released pin.
	logic [INPUT_PIN_COUNT-1:0] cap_oe;    // Output enables of the input-capable pins.
	// The pattern flips every 32 cycles so the synchroniser always has time to settle.
	always_ff @(negedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tick      <= '0;
			drive_pat <= 3'h5;
		end else begin
			tick <= tick + 5'h1;
			if (tick == 5'h1f) begin
				drive_pat <= ~drive_pat;
			end
		end
	end
	// A driven pin reads back its own level; only a released pin shows the board pattern.
	assign cap_oe = pin_oe[INPUT_PIN_FIRST +: INPUT_PIN_COUNT];
	assign pin_in = (pin_out[INPUT_PIN_FIRST +: INPUT_PIN_COUNT] & cap_oe) |
		(drive_pat & ~cap_oe);
endmodule // spr_pin_monitor

/* dv/spr_router_bench.sv */
// Self-checking testbench for the status output pin router.
`timescale 1ns/100ps
module spr_router_bench;
	import spr_pkg::*;
	logic                       core_clk, rst_n, rd_q;   // Clock, reset, read in flight.
	spr_reg_req_t               reg_req;                 // Control port access.
	spr_status_t                rx_status;               // Routed status sources.
	spr_sample_t                sample_in;               // Incoming samples.
	logic [INT_EVT_W-1:0]       flag_event;              // Flag event pulses.
	logic [REG_DATA_W-1:0]      reg_rdata;               // Read data.
	logic [SAMPLE_W-1:0]        sample_out, last_good;   // Output sample and model state.
	logic                       sample_out_strobe, interrupt_out_n;
	logic [INPUT_PIN_COUNT-1:0] pin_in, alt_rx_data, alt_rx_cmos_en, alt_rx_cmp_en;
	logic [PIN_COUNT-1:0]       pin_out, pin_oe;
	logic [REG_DATA_W-1:0]      rd_exp[$];               // Expected read data, oldest first.
	logic [SAMPLE_W-1:0]        smp_exp[$];              // Expected samples, oldest first.
	int                         num_errors, n_tests;
	spr_router u_dut (.core_clk(core_clk), .rst_n(rst_n), .reg_req(reg_req),
		.reg_rdata(reg_rdata), .rx_status(rx_status), .flag_event(flag_event),
		.sample_in(sample_in), .sample_out(sample_out), .sample_out_strobe(sample_out_strobe),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .alt_rx_data(alt_rx_data),
		.alt_rx_cmos_en(alt_rx_cmos_en), .alt_rx_cmp_en(alt_rx_cmp_en),
		.interrupt_out_n(interrupt_out_n));
	spr_pin_monitor u_far (.core_clk(core_clk), .rst_n(rst_n), .pin_out(pin_out),
		.pin_oe(pin_oe), .pin_in(pin_in));
	// Compare tasks: wide values and single pins.
	task automatic cmp_word(input logic [SAMPLE_W-1:0] got, input logic [SAMPLE_W-1:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp_bit(input logic got, input logic exp);
		cmp_word(SAMPLE_W'(got), SAMPLE_W'(exp));
	endtask
	task automatic print_verdict();
		$display("Checks %0d, errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// Bus cycles hold the access for one full edge, then release it.
	task automatic reg_wr(input logic [REG_ADDR_W-1:0] a, input logic [REG_DATA_W-1:0] d);
		@(negedge core_clk);
		reg_req <= '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
		@(negedge core_clk);
		reg_req <= '0;
	endtask
	task automatic reg_rd(input logic [REG_ADDR_W-1:0] a, input logic [REG_DATA_W-1:0] e);
		@(negedge core_clk);
		reg_req <= '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: '0};
		rd_exp.push_back(e);
		@(negedge core_clk);
		reg_req <= '0;
	endtask
	// The model keeps the last usable sample for the hold policy.
	task automatic send_sample(input logic fill, input logic ovr);
		spr_sample_t t;
		logic        u;
		t = '{strobe: 1'b1, invalid: 1'($urandom), corrupt: ($urandom % 3 == 0),
			data: 24'($urandom)};
		u = !t.corrupt && (ovr || !t.invalid);
		if (u) last_good = t.data;
		smp_exp.push_back(u ? t.data : (fill ? '0 : last_good));
		@(negedge core_clk);
		sample_in <= t;
		@(negedge core_clk);
		sample_in.strobe <= 1'b0;
	endtask
	// Results are checked where they settle, half a cycle after the edge.
	always @(posedge core_clk) rd_q <= reg_req.rd_en;
	always @(negedge core_clk) begin
		if (rd_q) cmp_word(SAMPLE_W'(reg_rdata), SAMPLE_W'(rd_exp.pop_front()));
		if (sample_out_strobe === 1'b1) cmp_word(sample_out, smp_exp.pop_front());
	end
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	// A hang counts as a mismatch.
	initial begin
		repeat (20000) @(posedge core_clk);
		num_errors++;
		print_verdict();
	end
	initial begin
		rst_n = 1'b0;
		reg_req = '0;
		rx_status = '0;
		flag_event = '0;
		sample_in = '0;
		last_good = '0;
		num_errors = 0;
		n_tests = 0;
		void'($urandom(32));
		repeat (2) @(negedge core_clk);
		rst_n = 1'b1;
		// Reset codes, then an unmapped hole.
		for (int r = 0; r < ROUTE_REG_COUNT; r++) begin
			reg_rd(ADDR_ROUTE_A + REG_ADDR_W'(r), {1'b0, 4'(2 * r + 1), 4'(2 * r)});
		end
		reg_rd(7'h30, 9'h000);
		cmp_word(SAMPLE_W'(pin_oe), SAMPLE_W'(10'h3ff));
		// Every output code on two pins; code zero shows the idle interrupt.
		for (int c = 0; c < 14; c++) begin
			rx_status <= spr_status_t'(13'($urandom));
			reg_wr(ADDR_ROUTE_A, {1'b0, 4'(c), 4'(c)});
			reg_wr(ADDR_ROUTE_E, {1'b0, 4'(c), 4'h8});
			repeat (2) @(negedge core_clk);
			cmp_bit(pin_out[1], c == 0 ? 1'b1 : rx_status[13 - c]);
			cmp_bit(pin_out[9], c == 0 ? 1'b1 : rx_status[13 - c]);
			rx_status <= ~rx_status;
			repeat (2) @(negedge core_clk);
			cmp_bit(pin_out[1], c == 0 ? 1'b1 : rx_status[13 - c]);
			cmp_bit(pin_out[9], c == 0 ? 1'b1 : rx_status[13 - c]);
		end
		// Input codes on all three capable pins and on several non-capable ones.
		reg_wr(ADDR_ROUTE_A, 9'h0e0);
		reg_wr(ADDR_ROUTE_B, 9'h0fe);
		reg_wr(ADDR_ROUTE_C, 9'h0ef);
		reg_wr(ADDR_ROUTE_D, 9'h0fe);
		reg_wr(ADDR_ROUTE_E, 9'h0ef);
		repeat (2) @(negedge core_clk);
		cmp_word(SAMPLE_W'({pin_oe[4:2], alt_rx_cmos_en, alt_rx_cmp_en}),
			SAMPLE_W'(9'b000001110));
		cmp_word(SAMPLE_W'({pin_oe[9:5], pin_out[9:5], pin_oe[1], pin_out[1]}),
			SAMPLE_W'(12'hf82));
		for (int w = 0; w < 8 && alt_rx_data !== pin_in; w++) @(negedge core_clk);
		cmp_word(SAMPLE_W'(alt_rx_data), SAMPLE_W'(pin_in));
		// Hold policy first, then zero fill, each with and without override.
		for (int m = 0; m < 4; m++) begin
			reg_wr(ADDR_ROUTE_A, {m[1], 8'h10});
			reg_wr(ADDR_ROUTE_B, {m[0], 8'h32});
			for (int s = 0; s < 12; s++) send_sample(m[1], m[0]);
		end
		// Each flag event raises the interrupt and is named in the cause register.
		for (int b = 0; b < INT_EVT_W; b++) begin
			@(negedge core_clk);
			flag_event <= INT_EVT_W'(1) << b;
			@(negedge core_clk);
			flag_event <= '0;
			cmp_bit(interrupt_out_n, 1'b0);
			@(negedge core_clk);
			cmp_bit(pin_out[0], 1'b0);
			reg_rd(ADDR_INT_STATUS, REG_DATA_W'(INT_EVT_W'(1) << b));
			reg_rd(ADDR_INT_STATUS, 9'h000);
			cmp_bit(interrupt_out_n, 1'b1);
		end
		repeat (2) @(negedge core_clk);
		cmp_word(SAMPLE_W'(rd_exp.size() + smp_exp.size()), '0);
		print_verdict();
	end
endmodule // spr_router_bench

/* rtl/spr_pkg.sv */
// Shared constants and types for the status output pin router.
package spr_pkg;
	// Geometry of the routed pins and their select fields.
	localparam int PIN_COUNT        = 10;
	localparam int SEL_W            = 4;
	localparam int INPUT_PIN_FIRST  = 2;
	localparam int INPUT_PIN_COUNT  = 3;
	localparam int ROUTE_REG_COUNT  = 5;
	localparam int INT_EVT_W        = 8;
	localparam int SAMPLE_W         = 24;

	// Control port widths.
	localparam int REG_ADDR_W = 7;
	localparam int REG_DATA_W = 9;

	// Register addresses, one per routing register plus the cause register.
	localparam logic [REG_ADDR_W-1:0] ADDR_ROUTE_A    = 7'h26;
	localparam logic [REG_ADDR_W-1:0] ADDR_ROUTE_B    = 7'h27;
	localparam logic [REG_ADDR_W-1:0] ADDR_ROUTE_C    = 7'h28;
	localparam logic [REG_ADDR_W-1:0] ADDR_ROUTE_D    = 7'h29;
	localparam logic [REG_ADDR_W-1:0] ADDR_ROUTE_E    = 7'h2a;
	localparam logic [REG_ADDR_W-1:0] ADDR_INT_STATUS = 7'h2b;

	// Field positions inside a routing register.
	localparam int LO_SEL_LSB = 0;
	localparam int HI_SEL_LSB = 4;
	localparam int POLICY_BIT = 8;

	// Select codes with a special meaning.
	localparam logic [SEL_W-1:0] SEL_INTERRUPT  = 4'h0;
	localparam logic [SEL_W-1:0] SEL_LAST_OUT   = 4'hd;
	localparam logic [SEL_W-1:0] SEL_INPUT_CMOS = 4'he;
	localparam logic [SEL_W-1:0] SEL_INPUT_CMP  = 4'hf;

	// Reset values: pin k resets to code k, packed four bits per pin.
	localparam logic [PIN_COUNT*SEL_W-1:0] RST_SEL_ALL = 40'h9876543210;
	localparam logic                       RST_FILL     = 1'h0;
	localparam logic                       RST_VALID_OVR = 1'h0;

	// Receiver status bits that may be routed to a pin.
	typedef struct packed {
		logic validity;
		logic user;
		logic chan;
		logic parity;
		logic subframe_clock;
		logic block_start_marker;
		logic lock_lost;
		logic chan_status_update_flag;
		logic rate_high_flag;
		logic zero_detect_flag;
		logic nonpcm_flag;
		logic copyright_free_flag;
		logic emphasis_flag;
	} spr_status_t;

	// One access from the serial control port decoder.
	typedef struct packed {
		logic                  wr_en;
		logic                  rd_en;
		logic [REG_ADDR_W-1:0] addr;
		logic [REG_DATA_W-1:0] wdata;
	} spr_reg_req_t;

	// One received audio sample with its quality flags.
	typedef struct packed {
		logic                strobe;
		logic                invalid;
		logic                corrupt;
		logic [SAMPLE_W-1:0] data;
	} spr_sample_t;
endpackage

/* rtl/spr_router.sv */
// Status output pin router with receiver fill and validity policies.
// Operation
// - Select codes route fourteen sources onto pins.
// - Input codes act only on pins three-five.
// - Code e CMOS buffer, f comparator buffer.
// - Fill zero holds last valid sample.
// - Fill one outputs zeros for bad samples.
// - Override one ignores the validity error flag.
// - Override zero honours the validity error flag.
// - Interrupt asserts on events, cause recorded.
`timescale 1ns/100ps
module spr_router
	import spr_pkg::*;
(
	// Clock and reset.
	input  wire logic                       core_clk,
	input  wire logic                       rst_n,
	// Register access from the serial control port decoder.
	input  wire spr_reg_req_t               reg_req,
	output logic [REG_DATA_W-1:0]           reg_rdata,
	// Receiver status sources and flag events.
	input  wire spr_status_t                rx_status,
	input  wire logic [INT_EVT_W-1:0]       flag_event,
	// Receiver samples in and policed samples out.
	input  wire spr_sample_t                sample_in,
	output logic [SAMPLE_W-1:0]             sample_out,
	output logic                            sample_out_strobe,
	// General purpose pins.
	input  wire logic [INPUT_PIN_COUNT-1:0] pin_in,
	output logic [PIN_COUNT-1:0]            pin_out,
	output logic [PIN_COUNT-1:0]            pin_oe,
	// Receiver inputs taken from pins, with buffer choice.
	output logic [INPUT_PIN_COUNT-1:0]      alt_rx_data,
	output logic [INPUT_PIN_COUNT-1:0]      alt_rx_cmos_en,
	output logic [INPUT_PIN_COUNT-1:0]      alt_rx_cmp_en,
	// Interrupt, active low.
	output logic                            interrupt_out_n
);
	logic [SEL_W-1:0]           route_sel [PIN_COUNT]; // Per pin source select.
	logic                       bad_data_substitute;   // Fill policy bit.
	logic                       validity_override;     // Ignore validity flag.
	logic [INT_EVT_W-1:0]       int_status;            // Sticky interrupt causes.
	logic [INT_EVT_W-1:0]       next_int_status;       // Cause register next value.
	logic [INPUT_PIN_COUNT-1:0] pin_sync1;             // First synchroniser stage.
	logic [INPUT_PIN_COUNT-1:0] pin_sync2;             // Second synchroniser stage.
	logic                       route_hit;             // Address hits a routing register.
	logic [2:0]                 route_idx;             // Which routing register.
	logic                       sample_usable;         // Sample passes the policies.
	logic [REG_ADDR_W-1:0]      addr_off;              // Offset from the first register.

	// Picks the source bit for one select code; input codes yield zero.
	function automatic logic route_source(input logic [SEL_W-1:0] code,
			input spr_status_t st, input logic irq_n);
		case (code)
			4'h0: route_source = irq_n;
			4'h1: route_source = st.validity;
			4'h2: route_source = st.user;
			4'h3: route_source = st.chan;
			4'h4: route_source = st.parity;
			4'h5: route_source = st.subframe_clock;
			4'h6: route_source = st.block_start_marker;
			4'h7: route_source = st.lock_lost;
			4'h8: route_source = st.chan_status_update_flag;
			4'h9: route_source = st.rate_high_flag;
			4'ha: route_source = st.zero_detect_flag;
			4'hb: route_source = st.nonpcm_flag;
			4'hc: route_source = st.copyright_free_flag;
			4'hd: route_source = st.emphasis_flag;
			default: route_source = 1'h0;
		endcase
	endfunction

	// True when a code turns a pin into a receiver input.
	function automatic logic is_input_code(input logic [SEL_W-1:0] code);
		is_input_code = (code == SEL_INPUT_CMOS) || (code == SEL_INPUT_CMP);
	endfunction

	// Address decode shared by the write and read paths.
	assign addr_off  = reg_req.addr - ADDR_ROUTE_A;
	assign route_hit = (reg_req.addr >= ADDR_ROUTE_A) && (reg_req.addr <= ADDR_ROUTE_E);
	assign route_idx = addr_off[2:0];

	// Select fields and policy bits; each register holds two pins.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < PIN_COUNT; i++) begin
				route_sel[i] <= RST_SEL_ALL[i*SEL_W +: SEL_W];
			end
			bad_data_substitute <= RST_FILL;
			validity_override   <= RST_VALID_OVR;
		end else if (reg_req.wr_en && route_hit) begin
			route_sel[{route_idx, 1'h0}] <= reg_req.wdata[LO_SEL_LSB +: SEL_W];
			route_sel[{route_idx, 1'h1}] <= reg_req.wdata[HI_SEL_LSB +: SEL_W];
			// Only the first two registers carry a policy bit.
			if (reg_req.addr == ADDR_ROUTE_A) begin
				bad_data_substitute <= reg_req.wdata[POLICY_BIT];
			end
			if (reg_req.addr == ADDR_ROUTE_B) begin
				validity_override <= reg_req.wdata[POLICY_BIT];
			end
		end
	end

	// Cause register: reading it clears, but a new event in that cycle wins.
	always_comb begin
		next_int_status = int_status;
		if (reg_req.rd_en && (reg_req.addr == ADDR_INT_STATUS)) begin
			next_int_status = '0;
		end
		next_int_status = next_int_status | flag_event;
	end

	// Sticky causes and the active-low interrupt level derived from them.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			int_status      <= '0;
			interrupt_out_n <= 1'h1;
		end else begin
			int_status      <= next_int_status;
			interrupt_out_n <= ~(|next_int_status);
		end
	end

	// Read data is registered; unmapped addresses read as zero.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= '0;
		end else if (reg_req.rd_en) begin
			if (route_hit) begin
				reg_rdata <= {1'h0, route_sel[{route_idx, 1'h1}], route_sel[{route_idx, 1'h0}]};
				if (reg_req.addr == ADDR_ROUTE_A) begin
					reg_rdata[POLICY_BIT] <= bad_data_substitute;
				end
				if (reg_req.addr == ADDR_ROUTE_B) begin
					reg_rdata[POLICY_BIT] <= validity_override;
				end
			end else if (reg_req.addr == ADDR_INT_STATUS) begin
				reg_rdata <= {1'h0, int_status};
			end else begin
				reg_rdata <= '0;
			end
		end
	end

	// Pin inputs come from outside the clock domain; two flops first.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_sync1 <= '0;
			pin_sync2 <= '0;
		end else begin
			pin_sync1 <= pin_in;
			pin_sync2 <= pin_sync1;
		end
	end

	// One output stage per pin; the interrupt source follows the same
	// next value as the interrupt output so the two agree from the first edge after reset.
	for (genvar p = 0; p < PIN_COUNT; p++) begin : g_pin
		localparam bit INPUT_OK = (p >= INPUT_PIN_FIRST) &&
			(p < INPUT_PIN_FIRST + INPUT_PIN_COUNT);
		always_ff @(posedge core_clk or negedge rst_n) begin
			if (!rst_n) begin
				pin_out[p] <= 1'h0;
				pin_oe[p]  <= 1'h0;
			end else if (INPUT_OK && is_input_code(route_sel[p])) begin
				pin_out[p] <= 1'h0;
				pin_oe[p]  <= 1'h0;
			end else begin
				// Input codes on other pins drive a quiet low.
				pin_out[p] <= route_source(route_sel[p], rx_status,
					~(|next_int_status));
				pin_oe[p]  <= 1'h1;
			end
		end
	end

	// Receiver inputs from the three capable pins, with buffer selection.
	for (genvar k = 0; k < INPUT_PIN_COUNT; k++) begin : g_alt
		always_ff @(posedge core_clk or negedge rst_n) begin
			if (!rst_n) begin
				alt_rx_data[k]    <= 1'h0;
				alt_rx_cmos_en[k] <= 1'h0;
				alt_rx_cmp_en[k]  <= 1'h0;
			end else begin
				alt_rx_cmos_en[k] <= route_sel[INPUT_PIN_FIRST+k] == SEL_INPUT_CMOS;
				alt_rx_cmp_en[k]  <= route_sel[INPUT_PIN_FIRST+k] == SEL_INPUT_CMP;
				alt_rx_data[k]    <= is_input_code(route_sel[INPUT_PIN_FIRST+k]) &
					pin_sync2[k];
			end
		end
	end

	// A sample is usable unless corrupt, or invalid while validity counts.
	assign sample_usable = !sample_in.corrupt &&
		(validity_override || !sample_in.invalid);

	// Policed sample path: good data passes, bad data holds or zeroes.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sample_out        <= '0;
			sample_out_strobe <= 1'h0;
		end else begin
			sample_out_strobe <= sample_in.strobe;
			if (sample_in.strobe) begin
				if (sample_usable) begin
					sample_out <= sample_in.data;
				end else if (bad_data_substitute) begin
					sample_out <= '0;
				end
				// Otherwise the last valid sample stays put.
			end
		end
	end

	// Checks of the routing and policy behaviour.
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	sequence s_bad_sample;
		sample_in.strobe && !sample_usable;
	endsequence

	AST_SEL_CODE_V: assert property ((route_sel[0] == 4'h1) |=>
		(pin_out[0] == $past(rx_status.validity)))
		else $error("Pin one does not follow validity.");
	AST_SEL_CODE_EMPHASIS_FLAG: assert property ((route_sel[9] == SEL_LAST_OUT) |=>
		(pin_out[9] == $past(rx_status.emphasis_flag)))
		else $error("Pin ten does not follow emphasis.");
	AST_INPUT_RELEASE: assert property (is_input_code(route_sel[3]) |=>
		!pin_oe[3])
		else $error("Input capable pin still driven.");
	AST_NO_INPUT_PIN1: assert property (is_input_code(route_sel[1]) |=>
		(pin_oe[1] && !pin_out[1]))
		else $error("Pin two left its output role.");
	AST_CMP_BUFFER: assert property ((route_sel[4] == SEL_INPUT_CMP) |=>
		(alt_rx_cmp_en[2] && !alt_rx_cmos_en[2]))
		else $error("Comparator buffer not chosen.");
	AST_CMOS_BUFFER: assert property ((route_sel[2] == SEL_INPUT_CMOS) |=>
		(alt_rx_cmos_en[0] && !alt_rx_cmp_en[0]))
		else $error("CMOS buffer not chosen.");
	AST_FILL_HOLD: assert property ((s_bad_sample ##0 !bad_data_substitute) |=>
		$stable(sample_out))
		else $error("Bad sample did not hold.");
	AST_FILL_ZERO: assert property ((s_bad_sample ##0 bad_data_substitute) |=>
		(sample_out == '0))
		else $error("Bad sample not zeroed.");
	AST_OVERRIDE: assert property ((sample_in.strobe && validity_override &&
		!sample_in.corrupt) |=> (sample_out == $past(sample_in.data)))
		else $error("Invalid sample refused under override.");
	AST_USE_VALIDITY: assert property ((sample_in.strobe && !validity_override &&
		sample_in.invalid) |=> (sample_out == ($past(bad_data_substitute) ?
		{SAMPLE_W{1'b0}} : $past(sample_out))))
		else $error("Invalid sample accepted.");
	AST_IRQ_EVENT: assert property ((flag_event != '0) |=>
		(!interrupt_out_n && ((int_status & $past(flag_event)) == $past(flag_event))))
		else $error("Event did not raise interrupt.");
	AST_WRITE_FOLLOW: assert property ((reg_req.wr_en && reg_req.addr == ADDR_ROUTE_D)
		|=> ((route_sel[6] == $past(reg_req.wdata[LO_SEL_LSB +: SEL_W])) &&
		(route_sel[7] == $past(reg_req.wdata[HI_SEL_LSB +: SEL_W]))) ##1
		(pin_oe[6] && pin_oe[7]))
		else $error("Rewritten pins not driven.");
endmodule // spr_router
